// ### src/sld_pkg.sv
package sld_pkg;
  // Clock and on-time of the detector before a timed sample is taken
  localparam int CLK_FREQ_MHZ = 100;
  localparam int ON_TIME_US = 100;
  localparam int ON_CYCLES = (ON_TIME_US * CLK_FREQ_MHZ + 0);
  // Enable register plus three synchroniser stages before a result is usable
  localparam int PIPE_CYCLES = 4;
  localparam int CNT_W = 16;

  // Threshold selector: eight equal ascending steps, code 0 lowest
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam int LEVEL_LOW_BASE_MV = 1050;
  localparam int LEVEL_STD_BASE_MV = 2200;
  localparam int LEVEL_STEP_MV = 50;
  localparam int LEVEL_STD_TOP_MV = LEVEL_STD_BASE_MV + 7 * LEVEL_STEP_MV;

  // Latch values: one means supply below threshold
  localparam logic LATCH_RESET = 1'h0;
  localparam logic SYNC_RESET = 1'h0;
  localparam int SYNC_COUNT = 2;
  localparam int SYNC_MAIN = 0;
  localparam int SYNC_SUB = 1;

  typedef enum logic [1:0] {
    SLD_IDLE,
    SLD_INSTR_WAIT,
    SLD_PERIODIC
  } sld_state_t;

  // Rising edge of cur against prev; swapping the arguments gives a falling edge
  function automatic logic sld_edge(input logic prev, input logic cur);
    sld_edge = ~prev & cur;
  endfunction
endpackage

// ### src/sld_sync.sv
`timescale 1ns/1ps
module sld_sync
  import sld_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1;
  logic s2;
  logic s3;
  logic next_q;

  // A change is taken only once the second and third stages agree
  always_comb begin
    next_q = q_out;
    if (s2 == s3) begin
      next_q = s3;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1 <= SYNC_RESET;
      s2 <= SYNC_RESET;
      s3 <= SYNC_RESET;
      q_out <= SYNC_RESET;
    end else begin
      s1 <= d_in;
      s2 <= s1;
      s3 <= s2;
      q_out <= next_q;
    end
  end

  AST_SYNC_AGREE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (q_out != $past(q_out)) |-> ($past(s2) == $past(s3)) && (q_out == $past(s3)))
    else $error("sync output changed without stage agreement");
endmodule

// ### src/sld_sampler.sv
`timescale 1ns/1ps
module sld_sampler
  import sld_pkg::*;
#(
  parameter int WAIT_CYCLES = ON_CYCLES + PIPE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WAIT_CYCLES - 1);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_busy;
  logic next_done;
  logic [CNT_W-1:0] run_len;

  // Holds the detector on for the full settle time, then flags the capture
  always_comb begin
    next_cnt = cnt;
    next_busy = busy_out;
    next_done = 1'b0;
    if (busy_out) begin
      if (cnt == LAST) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_cnt = '0;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end else if (start_in) begin
      next_busy = 1'b1;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      busy_out <= next_busy;
      done_out <= next_done;
    end
  end

  // Length of the current on window, read only by the check below
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      run_len <= '0;
    end else if (!busy_out) begin
      run_len <= '0;
    end else begin
      run_len <= run_len + CNT_W'(1);
    end
  end

  AST_ON_TIME: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out |-> (run_len == CNT_W'(WAIT_CYCLES)))
    else $error("capture before the detector was on long enough");

  AST_START_BUSY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start_in && !busy_out) |=> busy_out ##1 busy_out)
    else $error("sampler did not start");
endmodule

// ### src/sld_top.sv
`timescale 1ns/1ps
// Operation
// - Three-bit selector picks one of eight thresholds
// - Heavy-load and detect-on bits switch detection
// - Low sub latch runs periodic sampling until recovered
// - Each result is written into readable detect latch
// - Heavy-load rise loads latch after next instruction
// - Heavy-load held: sample on every 2 Hz tick
// - Periodic samples: detector on at least 100 us before capture
// - Detect-on falling edge loads the detect latch
// - Sub latch rise loads both latches after instruction
// - Sub latch held: both latches updated each tick
// - Writes control detection, reads return detect latch
module sld_top
  import sld_pkg::*;
#(
  parameter int ON_CYCLES_P = ON_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic HEAVY_LOAD_MODE_IN,
  input wire logic DETECT_ON_IN,
  input wire logic [SEL_W-1:0] THRESHOLD_SEL_IN,
  input wire logic INSTR_CYCLE_IN,
  input wire logic TICK_2HZ_IN,
  input wire logic COMP_LOW_IN,
  input wire logic SUB_COMP_LOW_IN,
  output logic DETECT_LATCH_OUT,
  output logic SUB_DETECT_LATCH_OUT,
  output logic DETECT_ENABLE_OUT,
  output logic [SEL_W-1:0] THRESHOLD_SEL_OUT
);
  logic [SYNC_COUNT-1:0] raw_in;
  logic [SYNC_COUNT-1:0] sync_q;
  logic comp_sync;
  logic sub_sync;

  sld_state_t state;
  sld_state_t next_state;
  logic hl_prev;
  logic don_prev;
  logic next_detect;
  logic next_sub;
  logic next_enable;
  logic [SEL_W-1:0] next_sel;

  logic hl_rise;
  logic don_fall;
  logic sub_set;
  logic auto_on;
  logic instr_capture;
  logic load_sub;
  logic smp_start;
  logic smp_busy;
  logic smp_done;

  assign raw_in[SYNC_MAIN] = COMP_LOW_IN;
  assign raw_in[SYNC_SUB] = SUB_COMP_LOW_IN;

  // Both comparator decisions come from the analog side and are asynchronous
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_COUNT; gi++) begin : g_sync
      sld_sync u_sync (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RSTN_IN),
        .d_in(raw_in[gi]),
        .q_out(sync_q[gi])
      );
    end
  endgenerate

  assign comp_sync = sync_q[SYNC_MAIN];
  assign sub_sync = sync_q[SYNC_SUB];

  sld_sampler #(
    .WAIT_CYCLES(ON_CYCLES_P + PIPE_CYCLES)
  ) u_sampler (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RSTN_IN),
    .start_in(smp_start),
    .busy_out(smp_busy),
    .done_out(smp_done)
  );

  // Sampling sequencer
  always_comb begin
    hl_rise = sld_edge(hl_prev, HEAVY_LOAD_MODE_IN);
    don_fall = sld_edge(DETECT_ON_IN, don_prev);
    sub_set = sld_edge(SUB_DETECT_LATCH_OUT, sub_sync);
    auto_on = HEAVY_LOAD_MODE_IN | SUB_DETECT_LATCH_OUT | sub_set;
    next_state = state;
    instr_capture = 1'b0;
    smp_start = 1'b0;
    case (state)
      SLD_IDLE: begin
        if (hl_rise || sub_set) begin
          next_state = SLD_INSTR_WAIT;
        end
      end
      SLD_INSTR_WAIT: begin
        // Sample taken when the instruction after the trigger has ended
        if (INSTR_CYCLE_IN) begin
          instr_capture = 1'b1;
          // A trigger in the capture cycle needs its own following instruction
          if (hl_rise || sub_set) begin
            next_state = SLD_INSTR_WAIT;
          end else begin
            next_state = auto_on ? SLD_PERIODIC : SLD_IDLE;
          end
        end
      end
      SLD_PERIODIC: begin
        if (hl_rise || sub_set) begin
          next_state = SLD_INSTR_WAIT;
        end else if (!auto_on && !smp_busy) begin
          next_state = SLD_IDLE;
        end else if (auto_on && TICK_2HZ_IN && !smp_busy) begin
          smp_start = 1'b1;
        end
      end
      default: begin
        next_state = SLD_IDLE;
      end
    endcase
  end

  // Latches, detector power and threshold
  always_comb begin
    next_sel = THRESHOLD_SEL_IN;
    next_detect = DETECT_LATCH_OUT;
    next_sub = SUB_DETECT_LATCH_OUT;
    load_sub = (instr_capture | smp_done) & SUB_DETECT_LATCH_OUT;
    if (instr_capture || smp_done || don_fall) begin
      next_detect = comp_sync;
    end
    if (load_sub) begin
      next_sub = sub_sync;
    end
    // A new low indication wins over a sample that clears the latch
    if (sub_set) begin
      next_sub = 1'b1;
    end
    // Detector stays powered only while a measurement is in progress
    next_enable = DETECT_ON_IN | (next_state == SLD_INSTR_WAIT) | smp_busy | smp_start;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      state <= SLD_IDLE;
      hl_prev <= 1'b0;
      don_prev <= 1'b0;
      DETECT_LATCH_OUT <= LATCH_RESET;
      SUB_DETECT_LATCH_OUT <= LATCH_RESET;
      DETECT_ENABLE_OUT <= 1'b0;
      THRESHOLD_SEL_OUT <= SEL_RESET;
    end else begin
      state <= next_state;
      hl_prev <= HEAVY_LOAD_MODE_IN;
      don_prev <= DETECT_ON_IN;
      DETECT_LATCH_OUT <= next_detect;
      SUB_DETECT_LATCH_OUT <= next_sub;
      DETECT_ENABLE_OUT <= next_enable;
      THRESHOLD_SEL_OUT <= next_sel;
    end
  end

  AST_SEL_FOLLOWS: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ##1 (THRESHOLD_SEL_OUT == $past(THRESHOLD_SEL_IN)))
    else $error("threshold select not forwarded");

  AST_DETECT_ON_POWER: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    DETECT_ON_IN |=> DETECT_ENABLE_OUT)
    else $error("detector not powered while detect-on is set");

  AST_HL_ARMS: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    ($rose(HEAVY_LOAD_MODE_IN) && state != SLD_INSTR_WAIT) |=>
      (state == SLD_INSTR_WAIT) && DETECT_ENABLE_OUT)
    else $error("heavy-load rise did not arm the instruction sample");

  AST_INSTR_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (state == SLD_INSTR_WAIT && INSTR_CYCLE_IN) |=>
      (DETECT_LATCH_OUT == $past(comp_sync))
      && (state != SLD_INSTR_WAIT || $past(hl_rise || sub_set)))
    else $error("instruction sample not loaded");

  AST_TICK_START: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (state == SLD_PERIODIC && TICK_2HZ_IN && !smp_busy && auto_on && !hl_rise && !sub_set)
      |=> smp_busy ##1 DETECT_ENABLE_OUT)
    else $error("2 Hz tick did not start a sample");

  AST_DONE_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    smp_done |=> (DETECT_LATCH_OUT == $past(comp_sync)))
    else $error("periodic sample not loaded");

  AST_DON_FALL: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    $fell(DETECT_ON_IN) |=> (DETECT_LATCH_OUT == $past(comp_sync)))
    else $error("detect-on clear did not load the latch");

  AST_SUB_SET: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (sub_sync && !SUB_DETECT_LATCH_OUT) |=> SUB_DETECT_LATCH_OUT && (state == SLD_INSTR_WAIT))
    else $error("sub latch rise not handled");

  AST_SUB_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (smp_done && SUB_DETECT_LATCH_OUT) |=> (SUB_DETECT_LATCH_OUT == $past(sub_sync)))
    else $error("sub latch not updated by periodic sample");

  AST_STOP_RECOVER: assert property (@(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (state == SLD_PERIODIC && !HEAVY_LOAD_MODE_IN && !SUB_DETECT_LATCH_OUT && !sub_sync
      && !smp_busy && !hl_rise) |=> (state == SLD_IDLE))
    else $error("periodic sampling kept running after recovery");
endmodule

// ### tb/sld_supply_model.sv
`timescale 1ns/1ps
module sld_supply_model
  import sld_pkg::*;
#(
  parameter int SUB_MV = 2100
) (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic [SEL_W-1:0] sel_in,
  input int mv_in,
  output logic comp_low_out,
  output logic sub_low_out
);
  logic junk = 1'h0;
  // An unpowered detector gives no usable decision, so show a toggling level
  always @(posedge clk_in) junk <= ~junk;
  assign comp_low_out = en_in ? (mv_in < LEVEL_STD_BASE_MV + int'(sel_in) * LEVEL_STEP_MV) : junk;
  assign sub_low_out = mv_in < SUB_MV;
endmodule

// ### tb/sld_top_tb.sv
`timescale 1ns/1ps
module sld_top_tb
  import sld_pkg::*;
;
  localparam int ONC = 8;
  logic clk, rstn, hl, don, instr, tick, comp, sub, dl, sl, en;
  logic [SEL_W-1:0] sel;
  logic [SEL_W-1:0] sel_o;
  int mv;
  int err_count = 0;
  int n_checks = 0;

  sld_top #(.ON_CYCLES_P(ONC)) i_sld_top (
    .SYS_CLK_IN(clk),
    .RSTN_IN(rstn),
    .HEAVY_LOAD_MODE_IN(hl),
    .DETECT_ON_IN(don),
    .THRESHOLD_SEL_IN(sel),
    .INSTR_CYCLE_IN(instr),
    .TICK_2HZ_IN(tick),
    .COMP_LOW_IN(comp),
    .SUB_COMP_LOW_IN(sub),
    .DETECT_LATCH_OUT(dl),
    .SUB_DETECT_LATCH_OUT(sl),
    .DETECT_ENABLE_OUT(en),
    .THRESHOLD_SEL_OUT(sel_o)
  );

  sld_supply_model i_sld_supply_model (
    .clk_in(clk),
    .en_in(en),
    .sel_in(sel_o),
    .mv_in(mv),
    .comp_low_out(comp),
    .sub_low_out(sub)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    #1;
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle strobe: tick when k is set, otherwise an instruction end
  task automatic pulse(input logic k);
    if (k) begin
      tick <= 1'h1;
    end else begin
      instr <= 1'h1;
    end
    w(1);
    tick <= 1'h0;
    instr <= 1'h0;
  endtask

  task automatic t_levels;
    for (int s = 0; s < 8; s++) begin
      for (int d = -1; d < 2; d += 2) begin
        w(1);
        sel <= s[SEL_W-1:0];
        mv <= LEVEL_STD_BASE_MV + s * LEVEL_STEP_MV + d;
        don <= 1'h1;
        w(ONC + 6);
        chk("enable_on", 3'h1, {2'h0, en});
        chk("sel_out", s[2:0], sel_o);
        w(1);
        don <= 1'h0;
        w(3);
        chk("latch", {2'h0, d < 0}, {2'h0, dl});
        chk("enable_off", 3'h0, {2'h0, en});
      end
    end
    $display("levels test done");
  endtask

  task automatic t_heavy;
    w(1);
    mv <= 2300;
    hl <= 1'h1;
    w(ONC + 6);
    pulse(1'h0);
    w(2);
    chk("hl_first", 3'h1, {2'h0, dl});
    mv <= 3000;
    pulse(1'h1);
    w(3);
    chk("hl_window_en", 3'h1, {2'h0, en});
    w(ONC + 12);
    chk("hl_tick", 3'h0, {2'h0, dl});
    chk("hl_idle_en", 3'h0, {2'h0, en});
    w(1);
    mv <= 2300;
    hl <= 1'h0;
    w(3);
    pulse(1'h1);
    w(ONC + 12);
    chk("hl_stopped", 3'h0, {2'h0, dl});
    $display("heavy load test done");
  endtask

  task automatic t_sub;
    w(1);
    mv <= 2000;
    w(6);
    chk("sub_set", 3'h1, {2'h0, sl});
    w(ONC);
    pulse(1'h0);
    w(2);
    chk("sub_both", 3'h3, {1'h0, sl, dl});
    mv <= 3000;
    pulse(1'h1);
    w(ONC + 12);
    chk("sub_clear", 3'h0, {1'h0, sl, dl});
    w(1);
    mv <= 2300;
    pulse(1'h1);
    w(ONC + 12);
    chk("sub_stopped", 3'h0, {1'h0, sl, dl});
    $display("sub detector test done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_count++;
    end_of_test;
  end

  initial begin
    rstn = 1'h0;
    hl = 1'h0;
    don = 1'h0;
    instr = 1'h0;
    tick = 1'h0;
    sel = 3'h0;
    mv = 3000;
    w(2);
    rstn <= 1'h1;
    chk("reset", 3'h0, {dl, sl, en});
    t_levels;
    t_heavy;
    t_sub;
    end_of_test;
  end
endmodule
